// ==== verilog/coar_consts.svh ====
// constants for the core operand addressing and register block
`ifndef COAR_CONSTS_SVH
`define COAR_CONSTS_SVH
// special-function addresses of the core registers
`define COAR_ADDR_STACK_POINTER   8'h81
`define COAR_ADDR_DATA_POINTER_16_LOW        8'h82
`define COAR_ADDR_DATA_POINTER_16_HIGH       8'h83
`define COAR_ADDR_ARITH_MAIN      8'he0
`define COAR_ADDR_ARITH_SECOND    8'hf0
// reset values
`define COAR_RST_STACK_POINTER    8'h07
`define COAR_RST_ZERO             8'h00
// direct space split
`define COAR_DIRECT_RAM_TOP       8'h7f
// special opcodes
`define COAR_OPC_IDLE             8'h00
`define COAR_OPC_UNASSIGNED       8'ha5
// bank layout: eight registers per bank
`define COAR_BANK_SHIFT           3
`endif

// ==== verilog/coar_pkg.sv ====
// types shared by the operand addressing block
package coar_pkg;
  typedef enum logic [2:0] {
    COAR_TGT_NONE  = 3'h0,
    COAR_TGT_REL   = 3'h1,
    COAR_TGT_PAGE  = 3'h3,
    COAR_TGT_FULL  = 3'h2
  } coar_target_t;
endpackage : coar_pkg

// ==== verilog/coar_operand_decode.sv ====
// combinational operand address and jump target decoding
`include "coar_consts.svh"
module coar_operand_decode (
  // operand fields
  input  wire logic [1:0]  bankSelectField,
  input  wire logic [2:0]  bankRegisterIndex,
  input  wire logic        pointerSelect,
  input  wire logic [7:0]  pointerValue,
  input  wire logic [7:0]  directAddress,
  // branch fields
  input  wire logic [15:0] nextPc,
  input  wire logic [7:0]  displacement,
  input  wire logic [10:0] pageTarget,
  input  wire logic [15:0] fullTarget,
  input  wire coar_pkg::coar_target_t targetKind,
  // results
  output logic [7:0]       bankRegisterAddr,
  output logic [7:0]       pointerRegAddr,
  output logic [7:0]       indirectAddr,
  output logic             directIsSfr,
  output logic [15:0]      branchTarget
);
  // ************************************************************
  // address of a banked register
  // ************************************************************
  function automatic logic [7:0] bankAddr(input logic [1:0] bank, input logic [2:0] idx);
    bankAddr = {3'h0, bank, idx}; // bank 3 lands on 0x18-0x1f
  endfunction : bankAddr

  wire logic [15:0] relTarget;
  wire logic [15:0] pageJoin;

  // register operand and pointer register in the chosen bank
  assign bankRegisterAddr = bankAddr(bankSelectField, bankRegisterIndex); // [RULE1] [RULE14]
  assign pointerRegAddr   = bankAddr(bankSelectField, {2'h0, pointerSelect}); // [RULE2]
  assign indirectAddr     = pointerValue; // [RULE2]
  // above the ram top the byte goes to the special-function space
  assign directIsSfr      = directAddress > `COAR_DIRECT_RAM_TOP; // [RULE4]

  // signed offset from the byte after the instruction
  assign relTarget = nextPc + {{8{displacement[7]}}, displacement}; // [RULE3]
  // page target keeps the upper five bits of the next address
  assign pageJoin  = {nextPc[15:11], pageTarget}; // [RULE5]

  // target selection
  assign branchTarget = (targetKind == coar_pkg::COAR_TGT_REL)  ? relTarget :
                        (targetKind == coar_pkg::COAR_TGT_PAGE) ? pageJoin :
                        (targetKind == coar_pkg::COAR_TGT_FULL) ? fullTarget : // [RULE6]
                        nextPc;
endmodule : coar_operand_decode

// ==== verilog/coar_core_regs.sv ====
// core operand addressing decoder and core special-function registers
//
// Contract
// [RULE1] a banked register operand picks one of eight registers in the bank named by the bank select field.
// [RULE2] an indirect operand addresses data ram through register zero or one of the active bank.
// [RULE3] short and conditional jumps add a signed 8-bit offset to the next instruction address.
// [RULE4] direct addresses up to 0x7f reach data ram, 0x80 to 0xff the special-function space.
// [RULE5] page call and jump replace the low 11 bits of the next address, staying in the 2 kB page.
// [RULE6] far call and jump use a full 16-bit target anywhere in program memory.
// [RULE7] the unassigned opcode 0xa5 behaves exactly as the idle opcode.
// [RULE8] software writes reserved bits with their documented values.
// [RULE9] the 16-bit data pointer is a low and a high half, both read/write and cleared at reset.
// [RULE10] the stack pointer holds the top of stack and is incremented before a stack store writes.
// [RULE11] the stack pointer resets to seven.
// [RULE12] the main arithmetic register is read/write, bit addressable and cleared at reset.
// [RULE13] the second arithmetic register is read/write, bit addressable and cleared at reset.
// [RULE14] bank select values 0 to 3 map to ram banks, bank 3 at 0x18 to 0x1f.
// [RULE15] each core register is read and written at its special-function direct address.
`include "coar_consts.svh"
module coar_core_regs (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        reset,
  // instruction fields from the fetch stage
  input  wire logic [7:0]  opcode,
  input  wire logic [1:0]  bankSelectField,
  input  wire logic [2:0]  bankRegisterIndex,
  input  wire logic        pointerSelect,
  input  wire logic [7:0]  pointerValue,
  input  wire logic [7:0]  directAddress,
  input  wire logic [15:0] nextPc,
  input  wire logic [7:0]  displacement,
  input  wire logic [10:0] pageTarget,
  input  wire logic [15:0] fullTarget,
  input  wire coar_pkg::coar_target_t targetKind,
  // direct special-function access
  input  wire logic        sfrWrite,
  input  wire logic        sfrRead,
  input  wire logic [7:0]  sfrAddr,
  input  wire logic [7:0]  sfrWriteData,
  // bit access on the bit-addressable registers
  input  wire logic        bitWrite,
  input  wire logic [7:0]  bitSfrAddr,
  input  wire logic [2:0]  bitIndex,
  input  wire logic        bitValue,
  // stack and pointer operations
  input  wire logic        stackStore,
  input  wire logic        stackLoad,
  input  wire logic        pointerLoad,
  input  wire logic [15:0] immediateWord,
  // decoded results
  output logic [7:0]       bankRegisterAddr,
  output logic [7:0]       pointerRegAddr,
  output logic [7:0]       indirectAddr,
  output logic             directIsSfr,
  output logic [15:0]      branchTarget,
  output logic             isIdle,
  output logic [7:0]       stackWriteAddr,
  // register state
  output logic [7:0]       sfrReadData,
  output logic             sfrHit,
  output logic [7:0]       stackPointer,
  output logic [15:0]      dataPointer16,
  output logic [7:0]       arithMainRegister,
  output logic [7:0]       secondArithRegister
);
  // ************************************************************
  // operand decoding
  // ************************************************************
  wire logic [7:0]  decBankAddr;
  wire logic [7:0]  decPtrAddr;
  wire logic [7:0]  decIndirect;
  wire logic        decIsSfr;
  wire logic [15:0] decTarget;

  coar_operand_decode uDecode (
    .bankSelectField   (bankSelectField),
    .bankRegisterIndex (bankRegisterIndex),
    .pointerSelect     (pointerSelect),
    .pointerValue      (pointerValue),
    .directAddress     (directAddress),
    .nextPc            (nextPc),
    .displacement      (displacement),
    .pageTarget        (pageTarget),
    .fullTarget        (fullTarget),
    .targetKind        (targetKind),
    .bankRegisterAddr  (decBankAddr),
    .pointerRegAddr    (decPtrAddr),
    .indirectAddr      (decIndirect),
    .directIsSfr       (decIsSfr),
    .branchTarget      (decTarget)
  );

  // unassigned opcode folds onto the idle opcode
  // later stages see one idle code, so the spare opcode needs no state of its own
  wire logic decIdle = (opcode == `COAR_OPC_IDLE) || (opcode == `COAR_OPC_UNASSIGNED); // [RULE7]

  // register the decoded results so every output leaves a flip-flop
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      bankRegisterAddr <= `COAR_RST_ZERO;
      pointerRegAddr   <= `COAR_RST_ZERO;
      indirectAddr     <= `COAR_RST_ZERO;
      directIsSfr      <= 1'b0;
      branchTarget     <= 16'h0000;
      isIdle           <= 1'b0;
    end else begin
      bankRegisterAddr <= decBankAddr;
      pointerRegAddr   <= decPtrAddr;
      indirectAddr     <= decIndirect;
      directIsSfr      <= decIsSfr;
      branchTarget     <= decTarget;
      isIdle           <= decIdle;
    end
  end

  // ************************************************************
  // special-function register decode
  // ************************************************************
  function automatic logic [7:0] setBit(input logic [7:0] v, input logic [2:0] i, input logic b);
    logic [7:0] r;
    r = v;
    r[i] = b;
    setBit = r;
  endfunction : setBit

  // write strobes per register; an address outside the map matches none and is dropped
  wire logic wrSp   = sfrWrite && (sfrAddr == `COAR_ADDR_STACK_POINTER); // [RULE15]
  wire logic wrDpl  = sfrWrite && (sfrAddr == `COAR_ADDR_DATA_POINTER_16_LOW);      // [RULE15]
  wire logic wrDph  = sfrWrite && (sfrAddr == `COAR_ADDR_DATA_POINTER_16_HIGH);     // [RULE15]
  wire logic wrAcc  = sfrWrite && (sfrAddr == `COAR_ADDR_ARITH_MAIN);    // [RULE15]
  wire logic wrB    = sfrWrite && (sfrAddr == `COAR_ADDR_ARITH_SECOND);  // [RULE15]
  wire logic bitAcc = bitWrite && (bitSfrAddr == `COAR_ADDR_ARITH_MAIN);   // [RULE12]
  wire logic bitB   = bitWrite && (bitSfrAddr == `COAR_ADDR_ARITH_SECOND); // [RULE13]

  // ************************************************************
  // next register values
  // ************************************************************
  // stack: pre-increment on store, post-decrement on load; a direct write wins
  wire logic [7:0] spPlusOne = stackPointer + 8'h01;
  wire logic [7:0] next_stackPointer =
    wrSp       ? sfrWriteData :
    stackStore ? spPlusOne :                // [RULE10]
    stackLoad  ? stackPointer - 8'h01 :
    stackPointer;

  // data pointer: direct byte writes take priority over the 16-bit load
  wire logic [7:0] next_dpLow  = wrDpl ? sfrWriteData : pointerLoad ? immediateWord[7:0]  : dataPointer16[7:0];
  wire logic [7:0] next_dpHigh = wrDph ? sfrWriteData : pointerLoad ? immediateWord[15:8] : dataPointer16[15:8];

  // bit-addressable registers accept byte or single-bit writes
  wire logic [7:0] next_arithMain =
    wrAcc ? sfrWriteData : bitAcc ? setBit(arithMainRegister, bitIndex, bitValue) : arithMainRegister;
  wire logic [7:0] next_arithSecond =
    wrB ? sfrWriteData : bitB ? setBit(secondArithRegister, bitIndex, bitValue) : secondArithRegister;

  // ************************************************************
  // read path
  // ************************************************************
  // read mux; unmapped addresses read zero and drop the hit flag
  wire logic [7:0] rdMux =
    (sfrAddr == `COAR_ADDR_STACK_POINTER) ? stackPointer :
    (sfrAddr == `COAR_ADDR_DATA_POINTER_16_LOW)      ? dataPointer16[7:0] :
    (sfrAddr == `COAR_ADDR_DATA_POINTER_16_HIGH)     ? dataPointer16[15:8] :
    (sfrAddr == `COAR_ADDR_ARITH_MAIN)    ? arithMainRegister :
    (sfrAddr == `COAR_ADDR_ARITH_SECOND)  ? secondArithRegister : `COAR_RST_ZERO;
  wire logic rdHit = (sfrAddr == `COAR_ADDR_STACK_POINTER) || (sfrAddr == `COAR_ADDR_DATA_POINTER_16_LOW) ||
                     (sfrAddr == `COAR_ADDR_DATA_POINTER_16_HIGH) || (sfrAddr == `COAR_ADDR_ARITH_MAIN) ||
                     (sfrAddr == `COAR_ADDR_ARITH_SECOND);

  // ************************************************************
  // register state
  // ************************************************************
  // the pushed byte goes to the incremented pointer, never the old one
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stackPointer   <= `COAR_RST_STACK_POINTER; // [RULE11]
      stackWriteAddr <= `COAR_RST_ZERO;
    end else begin
      stackPointer   <= next_stackPointer;
      stackWriteAddr <= spPlusOne;              // [RULE10]
    end
  end

  // ************************************************************
  // data pointer
  // ************************************************************
  // data pointer halves
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      dataPointer16 <= 16'h0000; // [RULE9]
    end else begin
      dataPointer16 <= {next_dpHigh, next_dpLow}; // [RULE9]
    end
  end

  // ************************************************************
  // arithmetic registers
  // ************************************************************
  // arithmetic registers
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      arithMainRegister   <= `COAR_RST_ZERO; // [RULE12]
      secondArithRegister <= `COAR_RST_ZERO; // [RULE13]
    end else begin
      arithMainRegister   <= next_arithMain;   // [RULE12]
      secondArithRegister <= next_arithSecond; // [RULE13]
    end
  end

  // ************************************************************
  // read data
  // ************************************************************
  // read data is held from one read to the next
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sfrReadData <= `COAR_RST_ZERO;
      sfrHit      <= 1'b0;
    end else if (sfrRead) begin
      sfrReadData <= rdMux; // [RULE15]
      sfrHit      <= rdHit;
    end
  end
endmodule : coar_core_regs

// ==== test/coar_core_regs_monitor.sv ====
// checker for the operand decoder and core registers, ports only
module coar_core_regs_monitor (
  // clock and reset
  input wire logic                   sys_clk,
  input wire logic                   reset,
  // decode inputs
  input wire logic [7:0]             opcode,
  input wire logic [7:0]             directAddress,
  input wire logic [7:0]             displacement,
  input wire logic [1:0]             bankSelectField,
  input wire logic [2:0]             bankRegisterIndex,
  input wire logic                   pointerSelect,
  input wire logic [15:0]            nextPc,
  input wire logic [15:0]            fullTarget,
  input wire logic [10:0]            pageTarget,
  input wire coar_pkg::coar_target_t targetKind,
  // register access
  input wire logic                   sfrWrite,
  input wire logic                   stackStore,
  input wire logic [7:0]             sfrAddr,
  input wire logic [7:0]             sfrWriteData,
  // outputs
  input wire logic [7:0]             bankRegisterAddr,
  input wire logic [7:0]             pointerRegAddr,
  input wire logic [7:0]             stackPointer,
  input wire logic [7:0]             stackWriteAddr,
  input wire logic [7:0]             arithMainRegister,
  input wire logic [7:0]             secondArithRegister,
  input wire logic                   directIsSfr,
  input wire logic                   isIdle,
  input wire logic [15:0]            branchTarget,
  input wire logic [15:0]            dataPointer16
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  // a push without a competing pointer write
  sequence s_push;
    stackStore && !(sfrWrite && sfrAddr == 8'h81);
  endsequence
  property p_bank;
    1'b1 |=> bankRegisterAddr == {3'h0, $past(bankSelectField), $past(bankRegisterIndex)};
  endproperty
  a_bank: assert property (p_bank) else $error("bank register address wrong");
  property p_ptr;
    1'b1 |=> pointerRegAddr == {3'h0, $past(bankSelectField), 2'h0, $past(pointerSelect)};
  endproperty
  a_ptr: assert property (p_ptr) else $error("pointer register address wrong");
  property p_direct;
    1'b1 |=> directIsSfr == ($past(directAddress) > 8'h7f);
  endproperty
  a_direct: assert property (p_direct) else $error("direct space split wrong");
  property p_rel;
    targetKind == coar_pkg::COAR_TGT_REL |=> branchTarget == $past(nextPc) + {{8{$past(displacement[7])}}, $past(displacement)};
  endproperty
  a_rel: assert property (p_rel) else $error("relative target wrong");
  property p_page;
    targetKind == coar_pkg::COAR_TGT_PAGE |=> branchTarget == {$past(nextPc[15:11]), $past(pageTarget)};
  endproperty
  a_page: assert property (p_page) else $error("page target wrong");
  property p_full;
    targetKind == coar_pkg::COAR_TGT_FULL |=> branchTarget == $past(fullTarget);
  endproperty
  a_full: assert property (p_full) else $error("full target wrong");
  property p_idle;
    opcode == 8'ha5 |=> isIdle;
  endproperty
  a_idle: assert property (p_idle) else $error("unassigned opcode not idle");
  property p_push;
    s_push |=> stackPointer == $past(stackPointer) + 8'h1 && stackWriteAddr == stackPointer;
  endproperty
  a_push: assert property (p_push) else $error("push did not pre-increment");
  property p_accwr;
    sfrWrite && sfrAddr == 8'he0 |=> arithMainRegister == $past(sfrWriteData);
  endproperty
  a_accwr: assert property (p_accwr) else $error("main register write lost");
  property p_dpwr;
    sfrWrite && sfrAddr == 8'h82 |=> dataPointer16[7:0] == $past(sfrWriteData);
  endproperty
  a_dpwr: assert property (p_dpwr) else $error("pointer low write lost");
  property p_bwr;
    sfrWrite && sfrAddr == 8'hf0 |=> secondArithRegister == $past(sfrWriteData);
  endproperty
  a_bwr: assert property (p_bwr) else $error("second register write lost");
endmodule : coar_core_regs_monitor

// ==== test/testbench.sv ====
// self-checking bench for the core operand addressing and register block
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk = 1'b0, reset = 1'b1, pointerSelect = 1'b0, sfrWrite = 1'b0, sfrRead = 1'b0, bitWrite = 1'b0;
  logic bitValue = 1'b0, stackStore = 1'b0, stackLoad = 1'b0, pointerLoad = 1'b0, directIsSfr, isIdle, sfrHit;
  logic [7:0] opcode = '0, pointerValue = '0, directAddress = '0, displacement = '0, sfrAddr = '0;
  logic [7:0] sfrWriteData = '0, bitSfrAddr = '0, bankRegisterAddr, pointerRegAddr, indirectAddr, stackWriteAddr;
  logic [7:0] sfrReadData, stackPointer, arithMainRegister, secondArithRegister;
  logic [1:0] bankSelectField = '0;
  logic [2:0] bankRegisterIndex = '0, bitIndex = '0;
  logic [10:0] pageTarget = '0;
  logic [15:0] nextPc = '0, fullTarget = '0, immediateWord = '0, branchTarget, dataPointer16;
  coar_pkg::coar_target_t targetKind = coar_pkg::COAR_TGT_NONE;
  int errTotal = 0, cmpCount = 0;
  coar_core_regs dut (.*);
  // clock: 40 ns period
  always #20 sys_clk = ~sys_clk;
  // ******************
  // shared tasks
  // ******************
  task chk(input logic [15:0] seen, exp);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // byte write, strobe held for exactly one edge
  task wr(input logic [7:0] a, d);
    @(posedge sys_clk) begin
      sfrWrite     <= 1'b1;
      sfrAddr      <= a;
      sfrWriteData <= d;
    end
    @(posedge sys_clk) sfrWrite <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] a, e, input logic h);
    @(posedge sys_clk) begin
      sfrRead <= 1'b1;
      sfrAddr <= a;
    end
    @(posedge sys_clk) sfrRead <= 1'b0;
    #1 chk(sfrReadData, e);
    chk(sfrHit, h);
  endtask : rd
  task stopTest;
    $display("comparisons %0d mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : stopTest
  // ******************
  // scenarios
  // ******************
  task automatic t_regs;
    logic [7:0] ad [5] = '{8'h81, 8'h82, 8'h83, 8'he0, 8'hf0};
    logic [7:0] dv [5] = '{8'h2f, 8'h34, 8'h12, 8'h5a, 8'h81};
    #1 chk(stackPointer, 8'h07);
    chk(dataPointer16, 16'h0);
    chk(arithMainRegister, 8'h0);
    chk(secondArithRegister, 8'h0);
    // whole bytes only, so no bit is ever left to chance
    foreach (ad[i]) wr(ad[i], dv[i]);
    foreach (ad[i]) rd(ad[i], dv[i], 1'b1);
    wr(8'h84, 8'hff); // unmapped write must vanish
    rd(8'h84, 8'h00, 1'b0);
    chk(dataPointer16, 16'h1234);
    $display("t_regs done");
  endtask : t_regs
  task automatic t_bits;
    @(posedge sys_clk) begin
      bitWrite   <= 1'b1;
      bitSfrAddr <= 8'he0;
      bitIndex   <= 3'h0;
      bitValue   <= 1'b1;
    end
    @(posedge sys_clk) begin
      bitSfrAddr <= 8'hf0;
      bitIndex   <= 3'h7;
      bitValue   <= 1'b0;
    end
    @(posedge sys_clk) bitWrite <= 1'b0;
    #1 chk(arithMainRegister, 8'h5b);
    chk(secondArithRegister, 8'h01);
    $display("t_bits done");
  endtask : t_bits
  task automatic t_stack;
    @(posedge sys_clk) stackStore <= 1'b1;
    @(posedge sys_clk) stackStore <= 1'b0;
    #1 chk(stackPointer, 8'h30);
    chk(stackWriteAddr, 8'h30);
    @(posedge sys_clk) begin
      stackLoad     <= 1'b1;
      pointerLoad   <= 1'b1;
      immediateWord <= 16'hbeef;
    end
    @(posedge sys_clk) begin
      stackLoad   <= 1'b0;
      pointerLoad <= 1'b0;
    end
    #1 chk(stackPointer, 8'h2f);
    chk(dataPointer16, 16'hbeef);
    @(posedge sys_clk) reset <= 1'b1;
    @(posedge sys_clk) reset <= 1'b0;
    #1 chk(stackPointer, 8'h07);
    chk(dataPointer16, 16'h0);
    chk(arithMainRegister, 8'h0);
    chk(secondArithRegister, 8'h0);
    $display("t_stack done");
  endtask : t_stack
  // one pass per bank, each with a different target kind; opcodes 0x00, 0xa5, 0x01, 0xa5
  task automatic t_decode;
    coar_pkg::coar_target_t tk [4] = '{coar_pkg::COAR_TGT_NONE, coar_pkg::COAR_TGT_REL,
                                      coar_pkg::COAR_TGT_PAGE, coar_pkg::COAR_TGT_FULL};
    logic [15:0] bt [4] = '{16'h3ffe, 16'h3f7e, 16'h3923, 16'h1abc};
    logic [7:0] op [4] = '{8'h00, 8'ha5, 8'h01, 8'ha5};
    for (int b = 0; b < 4; b++) begin
      @(posedge sys_clk) begin
        bankSelectField   <= b[1:0];
        bankRegisterIndex <= 3'h7;
        pointerSelect     <= b[0];
        pointerValue      <= 8'h40 + b[7:0];
        directAddress     <= 8'h7f + b[7:0];
        targetKind        <= tk[b];
        opcode            <= op[b];
        nextPc            <= 16'h3ffe;
        displacement      <= 8'h80;
        pageTarget        <= 11'h123;
        fullTarget        <= 16'h1abc;
      end
      @(posedge sys_clk) #1 chk(bankRegisterAddr, {b[1:0], 3'h7});
      chk(pointerRegAddr, {b[1:0], 2'h0, b[0]});
      chk(indirectAddr, 8'h40 + b[7:0]);
      chk(directIsSfr, b != 0);
      chk(branchTarget, bt[b]);
      chk(isIdle, b != 2);
    end
    $display("t_decode done");
  endtask : t_decode
  // main sequence
  initial begin
    repeat (10) @(posedge sys_clk);
    reset <= 1'b0;
    t_regs;
    t_bits;
    t_stack;
    t_decode;
    stopTest;
  end
endmodule : testbench
bind coar_core_regs coar_core_regs_monitor u_mon (.*);
